// *** hdl/cpipu_cfg.svh ***
/*
  Constants of the integer pack/unpack/add/subtract datapath: field positions,
  widths, opcodes and reset values.
  Assumes it is included by bare name after the package, once per file.
*/
`ifndef CPIPU_CFG_SVH
`define CPIPU_CFG_SVH

`define CPIPU_INSTR_W 15
`define CPIPU_OP6_HI 14
`define CPIPU_OP6_LO 9
`define CPIPU_OP9_LO 6
`define CPIPU_I_HI 8
`define CPIPU_I_LO 6
`define CPIPU_J_HI 5
`define CPIPU_J_LO 3
`define CPIPU_K_HI 2
`define CPIPU_K_LO 0
`define CPIPU_SEL_W 3
`define CPIPU_NREG 8
`define CPIPU_X_W 60
`define CPIPU_B_W 18
`define CPIPU_SIGN_BIT 59
`define CPIPU_COEF_W 48
`define CPIPU_EXP_W 11
`define CPIPU_EXP_HI 58
`define CPIPU_EXP_LO 48
`define CPIPU_OPC_PACK 6'h17
`define CPIPU_OPC_UNPACK 6'h16
`define CPIPU_OPC_ADD 6'h1e
`define CPIPU_OPC_SUB 6'h1f
`define CPIPU_OPC_9A 6'h01
`define CPIPU_OPC_9B 6'h03
`define CPIPU_OPC_9C 6'h26
`define CPIPU_X_RST 60'h0
`define CPIPU_B_RST 18'h0

`endif

// *** hdl/cpipu_pkg.sv ***
/*
  Types and decode function of the pack/unpack/add/subtract datapath.
  Assumes cpipu_cfg.svh is on the include path.
*/
package cpipu_pkg;
  `include "cpipu_cfg.svh"

  typedef enum logic [2:0] {
    CPIPU_OP_NONE = 3'b000,
    CPIPU_OP_PACK = 3'b001,
    CPIPU_OP_UNPACK = 3'b010,
    CPIPU_OP_ADD = 3'b011,
    CPIPU_OP_SUB = 3'b100,
    CPIPU_OP_OTHER = 3'b101
  } cpipu_op_t;

  typedef logic [`CPIPU_X_W-1:0] cpipu_xword_t;
  typedef logic [`CPIPU_B_W-1:0] cpipu_bword_t;
  typedef logic [`CPIPU_SEL_W-1:0] cpipu_sel_t;

  // Six-bit codes that the i field (instruction bits 8:6) extends to a nine-bit opcode
  function automatic logic cpipu_is_op9(input logic [5:0] op6);
    cpipu_is_op9 = (op6 == `CPIPU_OPC_9A) || (op6 == `CPIPU_OPC_9B) || (op6 == `CPIPU_OPC_9C);
  endfunction : cpipu_is_op9

  function automatic cpipu_op_t cpipu_decode(input logic [`CPIPU_INSTR_W-1:0] instr);
    logic [5:0] op6;
    op6 = instr[`CPIPU_OP6_HI:`CPIPU_OP6_LO];
    if (cpipu_is_op9(op6)) begin
      cpipu_decode = CPIPU_OP_OTHER;
    end else begin
      unique case (op6)
        `CPIPU_OPC_PACK: cpipu_decode = CPIPU_OP_PACK;
        `CPIPU_OPC_UNPACK: cpipu_decode = CPIPU_OP_UNPACK;
        `CPIPU_OPC_ADD: cpipu_decode = CPIPU_OP_ADD;
        `CPIPU_OPC_SUB: cpipu_decode = CPIPU_OP_SUB;
        default: cpipu_decode = CPIPU_OP_OTHER;
      endcase
    end
  endfunction : cpipu_decode
endpackage : cpipu_pkg

// *** hdl/cpipu_fu.sv ***
/*
  Combinational function unit: pack, unpack, integer add and subtract.
  Assumes operands are already selected; the caller registers the results.
*/
`include "cpipu_cfg.svh"

module cpipu_fu
  import cpipu_pkg::*;
(
  input wire cpipu_op_t op,
  input wire cpipu_xword_t xj,
  input wire cpipu_xword_t xk,
  input wire cpipu_bword_t bj,
  output cpipu_xword_t x_res,
  output cpipu_bword_t b_res
);
  logic sign_k;
  logic [`CPIPU_EXP_W-1:0] exp_in;
  logic [`CPIPU_EXP_W-1:0] exp_field;
  logic [`CPIPU_EXP_W-1:0] exp_raw;
  logic [`CPIPU_EXP_W-1:0] exp_unb;

  always_comb begin
    sign_k = xk[`CPIPU_SIGN_BIT];
    exp_in = bj[`CPIPU_EXP_W-1:0];
    exp_field = {~exp_in[`CPIPU_EXP_W-1], exp_in[`CPIPU_EXP_W-2:0]} ^ {`CPIPU_EXP_W{sign_k}};
    exp_raw = xk[`CPIPU_EXP_HI:`CPIPU_EXP_LO] ^ {`CPIPU_EXP_W{sign_k}};
    exp_unb = {~exp_raw[`CPIPU_EXP_W-1], exp_raw[`CPIPU_EXP_W-2:0]};
    x_res = '0;
    b_res = '0;
    unique case (op)
      CPIPU_OP_PACK: begin
        x_res = {sign_k, exp_field, xk[`CPIPU_COEF_W-1:0]};
      end
      CPIPU_OP_UNPACK: begin
        x_res = {{(`CPIPU_X_W-`CPIPU_COEF_W){sign_k}}, xk[`CPIPU_COEF_W-1:0]};
        b_res = {{(`CPIPU_B_W-`CPIPU_EXP_W){exp_unb[`CPIPU_EXP_W-1]}}, exp_unb};
      end
      CPIPU_OP_ADD: x_res = xj + xk;
      CPIPU_OP_SUB: x_res = xj - xk;
      CPIPU_OP_NONE, CPIPU_OP_OTHER: x_res = '0;
    endcase
  end
endmodule : cpipu_fu

// *** hdl/cpipu_alu.sv ***
/*
  Integer pack/unpack/add/subtract datapath with its operand and index
  register files.
  Assumes issue logic presents one undecoded 15-bit instruction at a time, synchronous
  to CORE_CLK, and loads/reads registers over the plain load and read ports.
*/
`include "cpipu_cfg.svh"

module cpipu_alu
  import cpipu_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RSTN,
  input wire logic ISSUE_VALID,
  input wire logic [`CPIPU_INSTR_W-1:0] ISSUE_INSTR,
  output logic ISSUE_READY,
  output logic DONE,
  output logic UNSUPPORTED,
  input wire logic LOAD_X_EN,
  input wire cpipu_sel_t LOAD_X_SEL,
  input wire cpipu_xword_t LOAD_X_DATA,
  input wire logic LOAD_B_EN,
  input wire cpipu_sel_t LOAD_B_SEL,
  input wire cpipu_bword_t LOAD_B_DATA,
  input wire cpipu_sel_t RD_X_SEL,
  output cpipu_xword_t RD_X_DATA,
  input wire cpipu_sel_t RD_B_SEL,
  output cpipu_bword_t RD_B_DATA
);
  cpipu_xword_t x_ff [`CPIPU_NREG];
  cpipu_xword_t nxt_x [`CPIPU_NREG];
  cpipu_bword_t b_ff [`CPIPU_NREG];
  cpipu_bword_t nxt_b [`CPIPU_NREG];
  cpipu_xword_t rd_x_ff;
  cpipu_xword_t nxt_rd_x;
  cpipu_bword_t rd_b_ff;
  cpipu_bword_t nxt_rd_b;
  logic done_ff;
  logic nxt_done;
  logic unsup_ff;
  logic nxt_unsup;

  cpipu_op_t op;
  cpipu_sel_t sel_i;
  cpipu_sel_t sel_j;
  cpipu_sel_t sel_k;
  cpipu_bword_t bj_val;
  cpipu_xword_t x_res;
  cpipu_bword_t b_res;
  logic fire;

  always_comb begin
    op = ISSUE_VALID ? cpipu_decode(ISSUE_INSTR) : CPIPU_OP_NONE;
    sel_i = ISSUE_INSTR[`CPIPU_I_HI:`CPIPU_I_LO];
    sel_j = ISSUE_INSTR[`CPIPU_J_HI:`CPIPU_J_LO];
    sel_k = ISSUE_INSTR[`CPIPU_K_HI:`CPIPU_K_LO];
    bj_val = b_ff[sel_j];
    fire = (op != CPIPU_OP_NONE) && (op != CPIPU_OP_OTHER);
  end

  // Single-cycle unit, always able to take an instruction
  assign ISSUE_READY = 1'b1;
  assign DONE = done_ff;
  assign UNSUPPORTED = unsup_ff;
  assign RD_X_DATA = rd_x_ff;
  assign RD_B_DATA = rd_b_ff;

  cpipu_fu u_fu (
    .op(op),
    .xj(x_ff[sel_j]),
    .xk(x_ff[sel_k]),
    .bj(bj_val),
    .x_res(x_res),
    .b_res(b_res)
  );

  // Register file next state; an executing instruction wins over a load
  always_comb begin
    for (int n = 0; n < `CPIPU_NREG; n++) begin
      nxt_x[n] = x_ff[n];
      nxt_b[n] = b_ff[n];
    end
    if (LOAD_X_EN) begin
      nxt_x[LOAD_X_SEL] = LOAD_X_DATA;
    end
    if (LOAD_B_EN) begin
      nxt_b[LOAD_B_SEL] = LOAD_B_DATA;
    end
    if (fire) begin
      nxt_x[sel_i] = x_res;
    end
    if (op == CPIPU_OP_UNPACK) begin
      nxt_b[sel_j] = b_res;
    end
    nxt_b[0] = `CPIPU_B_RST;
  end

  always_comb begin
    nxt_rd_x = x_ff[RD_X_SEL];
    nxt_rd_b = b_ff[RD_B_SEL];
    nxt_done = fire;
    nxt_unsup = (op == CPIPU_OP_OTHER);
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      for (int n = 0; n < `CPIPU_NREG; n++) begin
        x_ff[n] <= `CPIPU_X_RST;
        b_ff[n] <= `CPIPU_B_RST;
      end
      rd_x_ff <= `CPIPU_X_RST;
      rd_b_ff <= `CPIPU_B_RST;
      done_ff <= 1'b0;
      unsup_ff <= 1'b0;
    end else begin
      for (int n = 0; n < `CPIPU_NREG; n++) begin
        x_ff[n] <= nxt_x[n];
        b_ff[n] <= nxt_b[n];
      end
      rd_x_ff <= nxt_rd_x;
      rd_b_ff <= nxt_rd_b;
      done_ff <= nxt_done;
      unsup_ff <= nxt_unsup;
    end
  end
endmodule : cpipu_alu

// *** testbench/cpipu_alu_checker.sv ***
/* Port assertions of cpipu_alu.
   Bound to every cpipu_alu instance. */
module cpipu_alu_checker
  import cpipu_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RSTN,
  input wire logic ISSUE_VALID,
  input wire logic [14:0] ISSUE_INSTR,
  input wire logic DONE,
  input wire logic UNSUPPORTED,
  input wire logic LOAD_X_EN,
  input wire cpipu_sel_t LOAD_X_SEL,
  input wire cpipu_xword_t LOAD_X_DATA,
  input wire cpipu_sel_t RD_X_SEL,
  input wire cpipu_xword_t RD_X_DATA,
  input wire cpipu_sel_t RD_B_SEL,
  input wire cpipu_bword_t RD_B_DATA
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RSTN);
  wire logic [5:0] opc = ISSUE_INSTR[14:9];
  a_pack_done: assert property (ISSUE_VALID && opc == 6'h17 |=> DONE) else $error("pack");
  a_unpack_done: assert property (ISSUE_VALID && opc == 6'h16 |=> DONE) else $error("unpack");
  a_add_done: assert property (ISSUE_VALID && opc == 6'h1e |=> DONE) else $error("add");
  a_sub_done: assert property (ISSUE_VALID && opc == 6'h1f |=> DONE) else $error("sub");
  a_other_refused: assert property (ISSUE_VALID && !(opc inside {6'h16, 6'h17, 6'h1e, 6'h1f})
    |=> UNSUPPORTED && !DONE) else $error("other");
  a_idle_quiet: assert property (!ISSUE_VALID |=> !DONE && !UNSUPPORTED) else $error("idle");
  a_index_zero: assert property (RD_B_SEL == 3'h0 |=> RD_B_DATA == 18'h0) else $error("b0");
  a_load_readback: assert property (LOAD_X_EN && !ISSUE_VALID ##1 RD_X_SEL == $past(LOAD_X_SEL) && !LOAD_X_EN
    |=> RD_X_DATA == $past(LOAD_X_DATA, 2)) else $error("load");
  cover property (DONE);
  cover property (UNSUPPORTED);
  cover property (LOAD_X_EN && LOAD_X_SEL == 3'h0);
endmodule : cpipu_alu_checker

bind cpipu_alu cpipu_alu_checker u_chk (
  .CORE_CLK(CORE_CLK),
  .RSTN(RSTN),
  .ISSUE_VALID(ISSUE_VALID),
  .ISSUE_INSTR(ISSUE_INSTR),
  .DONE(DONE),
  .UNSUPPORTED(UNSUPPORTED),
  .LOAD_X_EN(LOAD_X_EN),
  .LOAD_X_SEL(LOAD_X_SEL),
  .LOAD_X_DATA(LOAD_X_DATA),
  .RD_X_SEL(RD_X_SEL),
  .RD_X_DATA(RD_X_DATA),
  .RD_B_SEL(RD_B_SEL),
  .RD_B_DATA(RD_B_DATA)
);

// *** testbench/cpipu_issue_model.sv ***
/* Issue-side model: one parcel per edge.
   Assumes the caller packs the fields. */
module cpipu_issue_model (
  input wire logic clk,
  output logic valid,
  output logic [14:0] instr
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    valid = 1'b0;
    instr = 15'h0;
  end
  task automatic send(logic [14:0] p);
    valid <= 1'b1;
    instr <= p;
    @(posedge clk);
    #1;
  endtask : send
  // Released parcel shows noise
  task automatic stop();
    valid <= 1'b0;
    instr <= 15'($urandom);
  endtask : stop
endmodule : cpipu_issue_model

// *** testbench/cpipu_alu_test.sv ***
/* Random bench of cpipu_alu with a register model.
   Assumes cpipu_issue_model drives the issue port. */
module cpipu_alu_test;
  import cpipu_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rstn = 0, xe = 0, v, done, uns, rdy;
  logic [14:0] ins;
  cpipu_sel_t xs = 0, rs = 0;
  cpipu_xword_t xd = 0, rx, xm[8];
  cpipu_bword_t rb, bm[8];
  logic [5:0] oc[8] = '{6'h17, 6'h16, 6'h1e, 6'h1f, 6'h01, 6'h03, 6'h26, 6'h05};
  logic q[$];
  int error_cnt = 0, check_count = 0;
  initial forever #2.5 clk = ~clk;
  cpipu_issue_model pm (.clk(clk), .valid(v), .instr(ins));
  cpipu_alu dut (.CORE_CLK(clk), .RSTN(rstn), .ISSUE_VALID(v), .ISSUE_INSTR(ins), .ISSUE_READY(rdy), .DONE(done),
    .UNSUPPORTED(uns), .LOAD_X_EN(xe), .LOAD_X_SEL(xs), .LOAD_X_DATA(xd), .LOAD_B_EN(xe), .LOAD_B_SEL(xs),
    .LOAD_B_DATA(xd[17:0]), .RD_X_SEL(rs), .RD_X_DATA(rx), .RD_B_SEL(rs), .RD_B_DATA(rb));
  task automatic chk(string n, logic [59:0] e, s);
    check_count++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h got %h", n, e, s);
    end
  endtask : chk
  always @(posedge clk) begin
    #1;
    if (done === 1'b1 || uns === 1'b1) chk("result", q.size() ? (q.pop_front() ? 2'b10 : 2'b01) : 2'b11, {done, uns});
  end
  task automatic op(logic [5:0] o, cpipu_sel_t i, j, k);
    logic s;
    logic [10:0] e;
    s = xm[k][59];
    e = bm[j][10:0] ^ 11'h400 ^ {11{s}};
    q.push_back(o[5:1] == 5'h0b || o[5:1] == 5'h0f);
    case (o)
      6'h17: xm[i] = {s, e, xm[k][47:0]};
      6'h16: begin
        e = xm[k][58:48] ^ 11'h400 ^ {11{s}};
        bm[j] = j ? 18'(signed'(e)) : 18'h0;
        xm[i] = {{12{s}}, xm[k][47:0]};
      end
      6'h1e: xm[i] = xm[j] + xm[k];
      6'h1f: xm[i] = xm[j] - xm[k];
      default: ;
    endcase
    pm.send({o, i, j, k});
  endtask : op
  task automatic rd();
    for (int s = 0; s < 8; s++) begin
      rs = 3'(s);
      @(posedge clk);
      #1;
      chk("x", xm[s], rx);
      chk("b", 60'(bm[s]), 60'(rb));
      chk("ready", 60'h1, 60'(rdy));
    end
  endtask : rd
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    void'($urandom(22915));
    repeat (20) @(posedge clk);
    #1 rstn = 1;
    for (int r = 0; r < 5; r++) begin
      xe = 1;
      for (int s = 0; s < 8; s++) begin
        xs = 3'(s);
        rs = xs;
        xd = 60'({$urandom, $urandom});
        xm[s] = xd;
        bm[s] = s ? xd[17:0] : 18'h0;
        @(posedge clk);
        #1;
      end
      xe = 0;
      repeat (40) op(oc[$urandom % 8], 3'($urandom), 3'($urandom), 3'($urandom));
      pm.stop();
      rd();
      if (r == 2) begin
        rstn = 0;
        @(posedge clk);
        #1 rstn = 1;
        xm = '{default: '0};
        bm = '{default: '0};
        rd();
      end
    end
    chk("queue", 60'h0, 60'(q.size()));
    tally_and_finish();
  end
endmodule : cpipu_alu_test
